// file: core/can_mo_pkg.sv
// Purpose: shared types and constants of the message object handler
// Assumes: two-bit flag codes, up to 32 objects per node
// Notes:   flag codes 10 = set, 01 = reset, others leave a flag alone

package can_mo_pkg;

  // ----------------------------------------------------------------
  // sizes and codes
  // ----------------------------------------------------------------
  localparam int OBJ_W   = 5;
  localparam int MAX_OBJ = 32;
  localparam int CNT_W   = 16;
  localparam int DLC_W   = 4;
  localparam int DATA_W  = 64;

  typedef logic [OBJ_W-1:0] obj_idx_t;
  typedef logic [CNT_W-1:0] frame_cnt_t;

  localparam logic [1:0] FLAG_SET   = 2'h2;
  localparam logic [1:0] FLAG_RST   = 2'h1;
  localparam logic [2:0] MODE_STD   = 3'h0;
  localparam logic [2:0] MODE_BASE  = 3'h2;
  localparam logic [2:0] MODE_SLAVE = 3'h3;
  localparam logic       DIR_RX     = 1'b0;
  localparam logic       DIR_TX     = 1'b1;
  localparam logic       STEP_RX    = 1'b0;
  localparam logic       STEP_TX    = 1'b1;
  localparam logic       ONE_SHOT   = 1'b1;

  // ----------------------------------------------------------------
  // per-object state
  // ----------------------------------------------------------------
  // ovw doubles as the host update lock on objects asked to send
  typedef struct packed {
    logic [1:0] valid;
    logic [1:0] fresh;
    logic [1:0] rmt;
    logic [1:0] send_request;
    logic [1:0] ovw;
    logic [1:0] tx_ie;
    logic [1:0] rx_ie;
    logic [1:0] irq;
    logic [1:0] tx_irq;
    logic [1:0] rx_irq;
  } obj_ctrl_t;

  typedef struct packed {
    logic             dir;
    logic             one_shot;
    logic             step_src;
    logic [2:0]       mode;
    logic [OBJ_W-1:0] buffer_length_mask;
    obj_idx_t         ptr;
    logic [DLC_W-1:0] dlc;
  } obj_cfg_t;

  typedef struct packed {
    obj_idx_t         obj;
    logic [DLC_W-1:0] dlc;
    logic             remote;
  } tx_frame_t;

  typedef struct packed {
    obj_ctrl_t  ctrl;
    obj_cfg_t   cfg;
    frame_cnt_t cfc;
  } obj_status_t;

  localparam obj_ctrl_t  CTRL_RESET = obj_ctrl_t'({10{FLAG_RST}});
  localparam obj_cfg_t   CFG_RESET  = '0;
  localparam frame_cnt_t CNT_ONE    = 16'h0001;
  localparam obj_idx_t   PTR_ONE    = 5'h01;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // write code: 10 sets, 01 resets, 00 and 11 keep
  function automatic logic [1:0] flag_apply(input logic [1:0] cur,
                                            input logic [1:0] code);
    if (code == FLAG_SET || code == FLAG_RST) begin
      return code;
    end
    return cur;
  endfunction : flag_apply

  // circular step inside the masked bits only
  function automatic obj_idx_t ptr_step(input obj_idx_t   old,
                                        input logic [4:0] mask);
    obj_idx_t inc;
    inc = old + PTR_ONE;
    return (old & ~mask) | (inc & mask);
  endfunction : ptr_step

endpackage : can_mo_pkg

// file: core/lowest_first.sv
// Purpose: picks the lowest-numbered active request
// Assumes: purely combinational, used on same-clock vectors
// Notes:   idx is zero when nothing is requested

`timescale 1ns/10ps

module lowest_first #(
  parameter int N = 32
) (
  input  wire logic [N-1:0]               req,
  output logic                            any,
  output can_mo_pkg::obj_idx_t            idx
);

  initial begin
    if (N < 2 || N > can_mo_pkg::MAX_OBJ) begin
      $error("lowest_first: N out of range");
    end
  end

  // scan downward so the lowest index is the last to win
  always_comb begin
    any = 1'b0;
    idx = '0;
    for (int k = N - 1; k >= 0; k--) begin
      if (req[k]) begin
        any = 1'b1;
        idx = can_mo_pkg::obj_idx_t'(k);
      end
    end
  end

endmodule : lowest_first

// file: core/obj_data_mem.sv
// Purpose: data partitions of all message objects
// Assumes: one write port, one read port, same clock
// Notes:   read data leave a register, one cycle after the request

`timescale 1ns/10ps

module obj_data_mem #(
  parameter int DEPTH = 32,
  parameter int WIDTH = 64
) (
  input  wire logic                     clk,
  input  wire logic                     we,
  input  wire can_mo_pkg::obj_idx_t     waddr,
  input  wire logic [WIDTH-1:0]         wdata,
  input  wire logic                     re,
  input  wire can_mo_pkg::obj_idx_t     raddr,
  output logic      [WIDTH-1:0]         rdata_q
);

  logic [WIDTH-1:0] mem [DEPTH];

  initial begin
    if (DEPTH < 2 || DEPTH > can_mo_pkg::MAX_OBJ) begin
      $error("obj_data_mem: DEPTH out of range");
    end
  end

  // no reset on the array; unused bytes may hold anything
  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    if (re) begin
      rdata_q <= mem[raddr];
    end
  end

endmodule : obj_data_mem

// file: core/can_msg_obj.sv
// Purpose: message object handling of one node: transmit completion,
//          receive storage, remote requests, one-shot mode and FIFOs
// Assumes: acceptance filtering is done outside and gives an index
// Notes:   software access is through plain ports, hardware wins
//
// Behaviour
// RQ1: among pending valid objects, lowest number transmits first
// RQ2: fresh data cleared when data are loaded for transmission
// RQ3: after data frame sent, clear remote request and send request
// RQ4: tx done captures counter, optional irq, then counter increments
// RQ5: transmit object ignores received data frames, raises no irq
// RQ6: received payload and length stored in the object
// RQ7: storing over unread fresh data sets the overwrite flag
// RQ8: every store sets fresh data
// RQ9: rx done captures counter, optional irq, then counter increments
// RQ10: receive object sends remote frame only while lock reads 01
// RQ11: after remote frame sent, clear requests, optional tx irq
// RQ12: receive object ignores remote frames, raises no irq
// RQ13: one-shot receive object invalidates itself after a store
// RQ14: one-shot transmit object invalidates itself after sending
// RQ15: without one-shot, hardware never clears object valid
// RQ16: software sizes FIFOs as power of two, aligned base
// RQ17: mode 010 is FIFO base, 011 is slave, same mask everywhere
// RQ18: transmit FIFO sends the currently addressed element
// RQ19: each FIFO element keeps its own flags and enables
// RQ20: software sets equal element setup, slaves point at base
// RQ21: base pointer steps circularly within the mask bits
// RQ22: step source picks receive or transmit actions
// RQ23: two-bit codes: 10 sets, 01 resets
// RQ24: valid, requested, unlocked transmit object sends when bus idle
// RQ25: hardware update beats a same-cycle software write

`timescale 1ns/10ps

module can_msg_obj #(
  parameter int N_OBJ = 32
) (
  input  wire logic                           clk,
  input  wire logic                           rst,
  // software side
  input  wire logic                           sw_ctrl_wr,
  input  wire can_mo_pkg::obj_ctrl_t          sw_ctrl,
  input  wire logic                           sw_cfg_wr,
  input  wire can_mo_pkg::obj_cfg_t           sw_cfg,
  input  wire logic                           sw_data_wr,
  input  wire logic [can_mo_pkg::DATA_W-1:0]  sw_data,
  input  wire can_mo_pkg::obj_idx_t           sw_obj,
  input  wire can_mo_pkg::obj_idx_t           sw_rd_obj,
  input  wire logic                           count_en,
  output can_mo_pkg::obj_status_t             status_q,
  output can_mo_pkg::frame_cnt_t              frame_cnt_q,
  // node side
  input  wire logic                           rx_data_valid,
  input  wire can_mo_pkg::obj_idx_t           rx_obj,
  input  wire logic [can_mo_pkg::DLC_W-1:0]   rx_dlc,
  input  wire logic [can_mo_pkg::DATA_W-1:0]  rx_payload,
  input  wire logic                           rx_remote_valid,
  input  wire can_mo_pkg::obj_idx_t           rx_remote_obj,
  input  wire logic                           tx_load,
  input  wire logic                           tx_ok,
  input  wire logic                           tx_abort,
  output logic                                tx_pend_q,
  output can_mo_pkg::tx_frame_t               tx_frame_q,
  output logic [can_mo_pkg::DATA_W-1:0]       tx_data_q
);

  initial begin
    if (N_OBJ < 2 || N_OBJ > can_mo_pkg::MAX_OBJ ||
        (N_OBJ & (N_OBJ - 1)) != 0) begin
      $error("can_msg_obj: N_OBJ must be a power of two up to 32");
    end
  end

  // ----------------------------------------------------------------
  // object state
  // ----------------------------------------------------------------
  can_mo_pkg::obj_ctrl_t  ctrl_q [N_OBJ];
  can_mo_pkg::obj_ctrl_t  ctrl_d [N_OBJ];
  can_mo_pkg::obj_cfg_t   cfg_q  [N_OBJ];
  can_mo_pkg::obj_cfg_t   cfg_d  [N_OBJ];
  can_mo_pkg::frame_cnt_t cfc_q  [N_OBJ];
  logic                   busy_q;
  can_mo_pkg::obj_idx_t   busy_obj_q;
  can_mo_pkg::obj_idx_t   tx_obj_q;
  logic [N_OBJ-1:0]       eligible;
  logic                   pick_any;
  can_mo_pkg::obj_idx_t   pick_idx;

  // ----------------------------------------------------------------
  // FIFO addressing
  // ----------------------------------------------------------------
  // RQ17 base and slave modes
  function automatic logic is_fifo(input can_mo_pkg::obj_cfg_t c);
    return c.mode == can_mo_pkg::MODE_BASE ||
           c.mode == can_mo_pkg::MODE_SLAVE;
  endfunction : is_fifo

  // a slave points at its base, a base is its own base
  function automatic can_mo_pkg::obj_idx_t base_of(
      input can_mo_pkg::obj_idx_t k, input can_mo_pkg::obj_cfg_t c);
    return (c.mode == can_mo_pkg::MODE_SLAVE) ? c.ptr : k;
  endfunction : base_of

  can_mo_pkg::obj_cfg_t rx_cfg;
  can_mo_pkg::obj_cfg_t rem_cfg;
  can_mo_pkg::obj_cfg_t busy_cfg;
  can_mo_pkg::obj_idx_t rx_base;
  can_mo_pkg::obj_idx_t rem_base;
  can_mo_pkg::obj_idx_t busy_base;
  can_mo_pkg::obj_idx_t rx_tgt;
  logic                 rx_accept;
  logic                 rx_store;
  logic                 rx_adv;
  logic                 rem_hit;
  logic                 rem_adv;
  logic                 txok_hit;
  logic                 tx_adv;
  logic                 load_hit;
  logic [1:0]           n_events;

  assign rx_cfg    = cfg_q[rx_obj];
  assign rem_cfg   = cfg_q[rx_remote_obj];
  assign busy_cfg  = cfg_q[busy_obj_q];
  assign rx_base   = base_of(rx_obj, rx_cfg);
  assign rem_base  = base_of(rx_remote_obj, rem_cfg);
  assign busy_base = base_of(busy_obj_q, busy_cfg);
  // RQ18 FIFO element addressed by base
  assign rx_tgt    = is_fifo(rx_cfg) ? cfg_q[rx_base].ptr : rx_obj;

  // RQ5 data frames reach receive objects only
  assign rx_accept = rx_data_valid && rx_cfg.dir == can_mo_pkg::DIR_RX &&
                     ctrl_q[rx_obj].valid == can_mo_pkg::FLAG_SET;
  // invalid addressed element: no store, pointer still steps
  assign rx_store  = rx_accept &&
                     ctrl_q[rx_tgt].valid == can_mo_pkg::FLAG_SET;
  // RQ12 remote frames reach transmit objects only
  assign rem_hit   = rx_remote_valid &&
                     rem_cfg.dir == can_mo_pkg::DIR_TX &&
                     ctrl_q[rx_remote_obj].valid == can_mo_pkg::FLAG_SET;
  assign txok_hit  = tx_ok && busy_q;
  assign load_hit  = tx_load && tx_pend_q && !busy_q;

  // RQ22 step on receive or transmit actions
  assign rx_adv    = rx_accept && is_fifo(rx_cfg) &&
                     rx_cfg.step_src == can_mo_pkg::STEP_RX;
  assign rem_adv   = rem_hit && is_fifo(rem_cfg) &&
                     rem_cfg.step_src == can_mo_pkg::STEP_RX;
  assign tx_adv    = txok_hit && is_fifo(busy_cfg) &&
                     busy_cfg.step_src == can_mo_pkg::STEP_TX;
  assign n_events  = {1'b0, rx_store} + {1'b0, txok_hit};

  // ----------------------------------------------------------------
  // per-object next state
  // ----------------------------------------------------------------
  for (genvar i = 0; i < N_OBJ; i++) begin : g_obj
    localparam can_mo_pkg::obj_idx_t ID = can_mo_pkg::obj_idx_t'(i);
    logic sw_hit;
    logic st_i;
    logic ld_i;
    logic rm_i;
    logic ok_i;
    logic adv_i;
    logic addressed;
    can_mo_pkg::obj_idx_t my_base;

    assign sw_hit  = sw_obj == ID;
    assign st_i    = rx_store && rx_tgt == ID;
    // only transmit-object loads clear fresh data; remote frames still load tx_data_q but leave fresh untouched
    assign ld_i    = load_hit && tx_obj_q == ID &&
                     cfg_q[i].dir == can_mo_pkg::DIR_TX;
    assign rm_i    = rem_hit && rx_remote_obj == ID;
    assign ok_i    = txok_hit && busy_obj_q == ID;
    assign adv_i   = (rx_adv && rx_base == ID) ||
                     (rem_adv && rem_base == ID) ||
                     (tx_adv && busy_base == ID);
    assign my_base = base_of(ID, cfg_q[i]);
    assign addressed = !is_fifo(cfg_q[i]) || cfg_q[my_base].ptr == ID;

    // RQ24 send when valid, requested, unlocked, addressed
    // RQ10 lock field must read 01 for any send
    assign eligible[i] = ctrl_q[i].valid == can_mo_pkg::FLAG_SET &&
                         ctrl_q[i].send_request == can_mo_pkg::FLAG_SET &&
                         ctrl_q[i].ovw == can_mo_pkg::FLAG_RST &&
                         addressed && !(busy_q && busy_obj_q == ID);

    // RQ19 flags held per element; software first, hardware after
    always_comb begin
      ctrl_d[i] = ctrl_q[i];
      cfg_d[i]  = cfg_q[i];
      // RQ23 coded flag writes
      if (sw_ctrl_wr && sw_hit) begin
        ctrl_d[i].valid  = can_mo_pkg::flag_apply(ctrl_q[i].valid,
                                                  sw_ctrl.valid);
        ctrl_d[i].fresh  = can_mo_pkg::flag_apply(ctrl_q[i].fresh,
                                                  sw_ctrl.fresh);
        ctrl_d[i].rmt    = can_mo_pkg::flag_apply(ctrl_q[i].rmt,
                                                  sw_ctrl.rmt);
        ctrl_d[i].send_request   = can_mo_pkg::flag_apply(ctrl_q[i].send_request,
                                                  sw_ctrl.send_request);
        ctrl_d[i].ovw    = can_mo_pkg::flag_apply(ctrl_q[i].ovw,
                                                  sw_ctrl.ovw);
        ctrl_d[i].tx_ie  = can_mo_pkg::flag_apply(ctrl_q[i].tx_ie,
                                                  sw_ctrl.tx_ie);
        ctrl_d[i].rx_ie  = can_mo_pkg::flag_apply(ctrl_q[i].rx_ie,
                                                  sw_ctrl.rx_ie);
        ctrl_d[i].irq    = can_mo_pkg::flag_apply(ctrl_q[i].irq,
                                                  sw_ctrl.irq);
        ctrl_d[i].tx_irq = can_mo_pkg::flag_apply(ctrl_q[i].tx_irq,
                                                  sw_ctrl.tx_irq);
        ctrl_d[i].rx_irq = can_mo_pkg::flag_apply(ctrl_q[i].rx_irq,
                                                  sw_ctrl.rx_irq);
      end
      if (sw_cfg_wr && sw_hit) begin
        cfg_d[i] = sw_cfg;
      end
      // RQ25 hardware updates below override the software write
      if (st_i) begin
        // RQ7 unread data overwritten
        if (ctrl_q[i].fresh == can_mo_pkg::FLAG_SET) begin
          ctrl_d[i].ovw = can_mo_pkg::FLAG_SET;
        end
        // RQ8 fresh always set on store
        ctrl_d[i].fresh = can_mo_pkg::FLAG_SET;
        // RQ6 length code follows the frame
        cfg_d[i].dlc = rx_dlc;
        // RQ9 receive interrupt
        if (ctrl_q[i].rx_ie == can_mo_pkg::FLAG_SET) begin
          ctrl_d[i].irq    = can_mo_pkg::FLAG_SET;
          ctrl_d[i].rx_irq = can_mo_pkg::FLAG_SET;
        end
        // RQ13 one-shot receive; RQ15 otherwise untouched
        if (cfg_q[i].one_shot == can_mo_pkg::ONE_SHOT) begin
          ctrl_d[i].valid = can_mo_pkg::FLAG_RST;
        end
      end
      // RQ2 fresh cleared at data load
      if (ld_i) begin
        ctrl_d[i].fresh = can_mo_pkg::FLAG_RST;
      end
      if (rm_i) begin
        ctrl_d[i].send_request = can_mo_pkg::FLAG_SET;
        ctrl_d[i].rmt  = can_mo_pkg::FLAG_SET;
      end
      if (ok_i) begin
        // RQ3 RQ11 requests done
        ctrl_d[i].rmt  = can_mo_pkg::FLAG_RST;
        ctrl_d[i].send_request = can_mo_pkg::FLAG_RST;
        // RQ4 transmit interrupt
        if (ctrl_q[i].tx_ie == can_mo_pkg::FLAG_SET) begin
          ctrl_d[i].irq    = can_mo_pkg::FLAG_SET;
          ctrl_d[i].tx_irq = can_mo_pkg::FLAG_SET;
        end
        // RQ14 one-shot transmit object
        if (cfg_q[i].one_shot == can_mo_pkg::ONE_SHOT &&
            cfg_q[i].dir == can_mo_pkg::DIR_TX) begin
          ctrl_d[i].valid = can_mo_pkg::FLAG_RST;
        end
      end
      // RQ21 circular pointer step
      if (adv_i) begin
        cfg_d[i].ptr = can_mo_pkg::ptr_step(cfg_q[i].ptr, cfg_q[i].buffer_length_mask);
      end
    end

    // RQ4 RQ9 counter captured before the increment
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        ctrl_q[i] <= can_mo_pkg::CTRL_RESET;
        cfg_q[i]  <= can_mo_pkg::CFG_RESET;
        cfc_q[i]  <= '0;
      end else begin
        ctrl_q[i] <= ctrl_d[i];
        cfg_q[i]  <= cfg_d[i];
        if (st_i || ok_i) begin
          cfc_q[i] <= frame_cnt_q;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // transmit selection and completion
  // ----------------------------------------------------------------
  // RQ1 lowest number first
  lowest_first #(.N(N_OBJ)) u_pick (
    .req (eligible),
    .any (pick_any),
    .idx (pick_idx)
  );

  // no frame offered while one is on its way; tx_obj_q keeps following the pick
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_pend_q  <= 1'b0;
      tx_obj_q   <= '0;
      busy_q     <= 1'b0;
      busy_obj_q <= '0;
    end else begin
      tx_pend_q <= pick_any && !busy_q && !load_hit;
      tx_obj_q  <= pick_idx;
      if (load_hit) begin
        busy_q     <= 1'b1;
        busy_obj_q <= tx_obj_q;
      end else if (tx_ok || tx_abort) begin
        busy_q <= 1'b0;
      end
    end
  end

  // RQ10 receive objects send a remote frame; tx_data_q still loads their data
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_frame_q <= '0;
    end else if (load_hit) begin
      tx_frame_q.obj    <= tx_obj_q;
      tx_frame_q.dlc    <= cfg_q[tx_obj_q].dlc;
      tx_frame_q.remote <= cfg_q[tx_obj_q].dir == can_mo_pkg::DIR_RX;
    end
  end

  // RQ4 RQ9 frame counter, one step per completed event
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      frame_cnt_q <= '0;
    end else if (count_en) begin
      frame_cnt_q <= frame_cnt_q + can_mo_pkg::frame_cnt_t'(n_events);
    end
  end

  // software read-back, one cycle late
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      status_q <= '0;
    end else begin
      status_q <= '{ctrl: ctrl_q[sw_rd_obj], cfg: cfg_q[sw_rd_obj],
                    cfc: cfc_q[sw_rd_obj]};
    end
  end

  // RQ6 payload storage, node store beats software write
  obj_data_mem #(.DEPTH(N_OBJ), .WIDTH(can_mo_pkg::DATA_W)) u_mem (
    .clk     (clk),
    .we      (rx_store || sw_data_wr),
    .waddr   (rx_store ? rx_tgt : sw_obj),
    .wdata   (rx_store ? rx_payload : sw_data),
    .re      (load_hit),
    .raddr   (tx_obj_q),
    .rdata_q (tx_data_q)
  );

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_load;
    load_hit && cfg_q[tx_obj_q].dir == can_mo_pkg::DIR_TX;
  endsequence
  sequence s_fresh_low(can_mo_pkg::obj_idx_t o);
    ctrl_q[o].fresh == can_mo_pkg::FLAG_RST;
  endsequence

  property p_load_fresh;
    can_mo_pkg::obj_idx_t o;
    (s_load, o = tx_obj_q) |=> s_fresh_low(o);
  endproperty
  a_load_fresh : assert property (p_load_fresh) // RQ2
    else $error("fresh data not cleared at load");

  property p_txok_clear;
    txok_hit |=> ctrl_q[$past(busy_obj_q)].send_request == can_mo_pkg::FLAG_RST &&
                 ctrl_q[$past(busy_obj_q)].rmt == can_mo_pkg::FLAG_RST;
  endproperty
  a_txok_clear : assert property (p_txok_clear) // RQ3
    else $error("requests not cleared after transmit");

  property p_store_fresh;
    rx_store |=> ctrl_q[$past(rx_tgt)].fresh == can_mo_pkg::FLAG_SET;
  endproperty
  a_store_fresh : assert property (p_store_fresh) // RQ8
    else $error("fresh data not set on store");

  property p_overwrite;
    rx_store && ctrl_q[rx_tgt].fresh == can_mo_pkg::FLAG_SET
      |=> ctrl_q[$past(rx_tgt)].ovw == can_mo_pkg::FLAG_SET;
  endproperty
  a_overwrite : assert property (p_overwrite) // RQ7
    else $error("overwrite not flagged");

  property p_cfc;
    rx_store |=> cfc_q[$past(rx_tgt)] == $past(frame_cnt_q);
  endproperty
  a_cfc : assert property (p_cfc) // RQ9
    else $error("frame count not captured");

  property p_cnt_inc;
    count_en && rx_store && !txok_hit
      |=> frame_cnt_q == $past(frame_cnt_q) + can_mo_pkg::CNT_ONE;
  endproperty
  a_cnt_inc : assert property (p_cnt_inc) // RQ9
    else $error("frame counter did not step by one");

  property p_one_shot;
    rx_store && cfg_q[rx_tgt].one_shot == can_mo_pkg::ONE_SHOT
      |=> ctrl_q[$past(rx_tgt)].valid == can_mo_pkg::FLAG_RST;
  endproperty
  a_one_shot : assert property (p_one_shot) // RQ13
    else $error("one-shot object still valid");

  property p_keep_valid;
    rx_store && cfg_q[rx_tgt].one_shot != can_mo_pkg::ONE_SHOT &&
      !sw_ctrl_wr |=> ctrl_q[$past(rx_tgt)].valid == can_mo_pkg::FLAG_SET;
  endproperty
  a_keep_valid : assert property (p_keep_valid) // RQ15
    else $error("valid cleared without one-shot");

  // other same-cycle updates of these flags are excluded
  property p_rx_ignore_remote;
    can_mo_pkg::obj_idx_t o;
    logic [1:0]           t;
    logic [1:0]           q;
    (rx_remote_valid && rem_cfg.dir == can_mo_pkg::DIR_RX && !sw_ctrl_wr &&
     !txok_hit && !rx_store, o = rx_remote_obj,
     t = ctrl_q[rx_remote_obj].send_request, q = ctrl_q[rx_remote_obj].irq)
      |=> ctrl_q[o].send_request == t && ctrl_q[o].irq == q;
  endproperty
  a_rx_ignore_remote : assert property (p_rx_ignore_remote) // RQ12
    else $error("receive object reacted to remote frame");

  property p_pick_locked;
    tx_pend_q |-> ctrl_q[tx_obj_q].ovw == can_mo_pkg::FLAG_RST ||
                  $past(sw_ctrl_wr) || $past(rx_store);
  endproperty
  a_pick_locked : assert property (p_pick_locked) // RQ10
    else $error("locked object offered for transmit");

endmodule : can_msg_obj

// file: testbench/can_node_model.sv
// Purpose: node side stand-in, loads offered frames and confirms them
// Assumes: one frame in flight, bus idle whenever nothing is in flight
// Notes:   DELAY sets how slowly the frame completes
`timescale 1ns/10ps
module can_node_model #(
  parameter int DELAY = 4
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic go,
  input  wire logic tx_pend_q,
  output logic      tx_load,
  output logic      tx_ok
);
  int cnt;
  // load when idle, then report success after DELAY cycles
  always @(negedge clk or posedge rst) begin
    if (rst) begin
      tx_load <= 1'b0;
      tx_ok   <= 1'b0;
      cnt     <= 0;
    end else begin
      tx_load <= 1'b0;
      tx_ok   <= 1'b0;
      if (cnt == 0 && go && tx_pend_q) begin
        tx_load <= 1'b1;
        cnt     <= DELAY;
      end else if (cnt == 1) begin
        tx_ok <= 1'b1;
        cnt   <= 0;
      end else if (cnt > 1) begin
        cnt <= cnt - 1;
      end
    end
  end
endmodule : can_node_model

// file: testbench/can_msg_obj_test.sv
// Purpose: self-checking bench of the message object handler
// Assumes: inputs change on the falling edge
// Notes:   abort and data writes are tied off for size
`timescale 1ns/10ps
module can_msg_obj_test;
  logic                    clk, rst, cw, fw, rxv, go, pend, ld, ok, ce, rv;
  can_mo_pkg::obj_ctrl_t   ctl;
  can_mo_pkg::obj_cfg_t    cfg;
  can_mo_pkg::obj_idx_t    so, ro, rxo, rmo;
  can_mo_pkg::frame_cnt_t  fc;
  logic [63:0]             td;
  can_mo_pkg::obj_status_t st;
  can_mo_pkg::tx_frame_t   txf;
  int                      error_cnt = 0, n_checks = 0, i;
  // {valid,fresh,ovw,cfc} after each of three stores
  logic [21:0] rows [3] = '{22'h290000, 22'h2a0001, 22'h2a0002};
  can_msg_obj i_dut (.clk(clk), .rst(rst), .sw_ctrl_wr(cw),
    .sw_ctrl(ctl), .sw_cfg_wr(fw), .sw_cfg(cfg), .sw_data_wr(1'b0),
    .sw_data(64'h0), .sw_obj(so), .sw_rd_obj(ro), .count_en(ce),
    .status_q(st), .frame_cnt_q(fc), .rx_data_valid(rxv), .rx_obj(rxo),
    .rx_dlc(4'h8), .rx_payload(64'h0123_4567_89ab_cdef),
    .rx_remote_valid(rv), .rx_remote_obj(rmo), .tx_load(ld),
    .tx_ok(ok), .tx_abort(1'b0), .tx_pend_q(pend), .tx_frame_q(txf),
    .tx_data_q(td));
  can_node_model i_node (.clk(clk), .rst(rst), .go(go),
    .tx_pend_q(pend), .tx_load(ld), .tx_ok(ok));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task chk(input logic [63:0] got, input logic [63:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task end_sim;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : end_sim
  // software writes of control codes and whole configuration
  task wr(input logic [4:0] o, input logic [1:0] ie, input logic d,
          input logic s);
    so = o;
    ctl = '0;
    ctl.valid = can_mo_pkg::FLAG_SET;
    ctl.send_request = d ? can_mo_pkg::FLAG_SET : 2'h0;
    ctl.ovw = can_mo_pkg::FLAG_RST;
    ctl.rx_ie = ie;
    ctl.tx_ie = ie;
    cfg = '0;
    cfg.dir = d;
    cfg.one_shot = s;
    cw = 1'b1;
    fw = 1'b1;
    @(negedge clk);
    cw = 1'b0;
    fw = 1'b0;
    @(negedge clk);
  endtask : wr
  task rx(input logic [4:0] o);
    rxo = o;
    rxv = 1'b1;
    @(negedge clk);
    rxv = 1'b0;
    ro = o;
    repeat (3) @(negedge clk);
  endtask : rx
  // bare control write; c holds the 2-bit codes of every flag
  task ctl_wr(input logic [4:0] o, input can_mo_pkg::obj_ctrl_t c);
    so = o;
    ctl = c;
    cw = 1'b1;
    @(negedge clk);
    cw = 1'b0;
    @(negedge clk);
  endtask : ctl_wr
  // two-element FIFO at base 8, slave points at base
  task fifo(input logic [4:0] o, input logic [2:0] m);
    so = o;
    cfg = '0;
    cfg.mode = m;
    cfg.buffer_length_mask = 5'h01;
    cfg.ptr = 5'h08;
    fw = 1'b1;
    @(negedge clk);
    fw = 1'b0;
    @(negedge clk);
  endtask : fifo
  // bounded wait until the node takes a frame
  task wait_ld;
    for (i = 0; i < 50 && ld !== 1'b1; i++) @(posedge clk);
    if (i == 50) begin
      error_cnt++;
      $display("MISMATCH %0t no frame taken", $time);
    end
    @(negedge clk);
  endtask : wait_ld
  initial begin
    {cw, fw, rxv, go, rv, so, ro, rxo, rmo, ctl, cfg} = '0;
    ce = 1'b1;
    rst = 1'b1;
    repeat (12) @(negedge clk);
    rst = 1'b0;
    repeat (3) @(negedge clk);
    chk(st.ctrl, can_mo_pkg::CTRL_RESET);
    wr(5'h02, can_mo_pkg::FLAG_SET, 1'b0, 1'b0);
    for (i = 0; i < 3; i++) begin
      rx(5'h02);
      chk({st.ctrl.valid, st.ctrl.fresh, st.ctrl.ovw, st.cfc}, rows[i]);
    end
    chk({st.ctrl.rx_irq, st.cfg.dlc}, 6'h28);
    wr(5'h04, 2'h0, 1'b0, 1'b1);
    rx(5'h04);
    chk(st.ctrl.valid, can_mo_pkg::FLAG_RST);
    wr(5'h07, 2'h0, 1'b1, 1'b0);
    wr(5'h05, can_mo_pkg::FLAG_SET, 1'b1, 1'b1);
    // nonblocking so the node model cannot race this edge
    go <= 1'b1;
    wait_ld;
    chk(txf.obj, 5'h05);
    ro = 5'h05;
    repeat (10) @(negedge clk);
    chk({st.ctrl.send_request, st.ctrl.rmt, st.ctrl.valid}, 6'h15);
    chk({st.ctrl.tx_irq, st.cfc}, 18'h20004);
    rx(5'h07);
    chk({st.ctrl.fresh, st.ctrl.irq}, 4'h5);
    // remote frame to a receive object
    rmo = 5'h02;
    rv = 1'b1;
    @(negedge clk);
    rv = 1'b0;
    ro = 5'h02;
    repeat (3) @(negedge clk);
    chk({st.ctrl.send_request, st.ctrl.irq}, 4'h6);
    // lock reads 10 after the overwrites: request held
    ctl_wr(5'h02, 20'h02000);
    repeat (8) @(negedge clk);
    chk({st.ctrl.send_request, pend}, 3'h4);
    ctl_wr(5'h02, 20'h00400);
    wait_ld;
    chk({txf.remote, txf.obj}, 6'h22);
    chk(td, 64'h0123_4567_89ab_cdef);
    repeat (8) @(negedge clk);
    chk({st.ctrl.send_request, st.ctrl.rmt, st.ctrl.tx_irq}, 6'h16);
    // base and slave, receive steps the pointer
    wr(5'h08, 2'h0, 1'b0, 1'b0);
    fifo(5'h08, can_mo_pkg::MODE_BASE);
    wr(5'h09, 2'h0, 1'b0, 1'b0);
    fifo(5'h09, can_mo_pkg::MODE_SLAVE);
    rx(5'h08);
    chk(st.cfg.ptr, 5'h09);
    rx(5'h08);
    chk({st.ctrl.fresh, st.ctrl.ovw, st.cfg.ptr}, 9'h128);
    ro = 5'h09;
    repeat (2) @(negedge clk);
    chk(st.ctrl.fresh, can_mo_pkg::FLAG_SET);
    ce = 1'b0;
    rx(5'h08);
    chk(fc, 16'h0009);
    end_sim;
  end
endmodule : can_msg_obj_test
